//--- design/alu_adder.sv
// Shared 24-bit adder with spill and overflow detection
`timescale 1ns/100ps
module alu_adder (
  input wire logic [23:0] a, // First addend
  input wire logic [23:0] b, // Second addend, already complemented for subtract
  input wire logic cin, // Carry into the least significant bit
  output logic [23:0] sum, // Sum
  output logic cout, // Carry out of the sign position
  output logic ovf // Same-sign inputs with a differing result
);
  logic [24:0] wide;
  always_comb begin
    wide = {1'b0, a} + {1'b0, b} + {24'h000000, cin};
    sum = wide[23:0];
    cout = wide[24];
    ovf = (a[23] == b[23]) && (sum[23] != a[23]); // RULE_01
  end
endmodule // alu_adder

//--- design/alu_cfg.svh
// Constants for the word-machine arithmetic, logic and branch datapath
// Overview of operation
// RULE_01: Add memory operand into main register in 2 cycles; same-sign inputs, differing result sets overflow.
// RULE_02: Add with spill adds the spill flag into the plain add sum.
// RULE_03: Add main register into memory, write back in 3 cycles, register unchanged.
// RULE_04: Subtract operand from main register; adder carry sets spill; opposite-sign overrange sets overflow.
// RULE_05: Subtract with spill: plain subtract if spill set, else add one's complement.
// RULE_06: Multiply in 14 cycles; 46-bit signed product, high in main, low in extension.
// RULE_07: Multiplying two most-negative operands sets overflow and forces zero product.
// RULE_08: Divide double dividend by memory in 28 cycles; remainder signed like dividend.
// RULE_09: Quotient outside minus one to plus one turns overflow on.
// RULE_10: Memory decrement writes back in 3 cycles; overflow as subtract.
// RULE_11: Memory increment writes back in 3 cycles; overflow as add.
// RULE_12: AND operand into main register in 2 cycles.
// RULE_13: Inclusive OR operand into main register in 2 cycles.
// RULE_14: Exclusive OR operand into main register in 2 cycles.
// RULE_15: Jump to effective address in 1 cycle.
// RULE_16: Increment index, branch if index bit 8 set, else next, in 1 cycle.
// RULE_17: Each indirect level adds one cycle to execution time.
// RULE_18: Words are 24-bit two's complement, bit 0 the sign.
`ifndef ALU_CFG_SVH
`define ALU_CFG_SVH
`define OPC_ADD 6'h2d
`define OPC_ADC 6'h2f
`define OPC_AAM 6'h33
`define OPC_SUB 6'h2c
`define OPC_SBC 6'h2e
`define OPC_MUL 6'h34
`define OPC_DIV 6'h35
`define OPC_DEC 6'h30
`define OPC_INC 6'h31
`define OPC_AND 6'h0c
`define OPC_OR 6'h0e
`define OPC_XOR 6'h0f
`define OPC_JMP 6'h01
`define OPC_BIX 6'h21
`define CYC_LOGIC 5'h02
`define CYC_MEM 5'h03
`define CYC_MUL 5'h0e
`define CYC_DIV 5'h1c
`define CYC_BRANCH 5'h01
`define MOST_NEG 24'h800000
`define IDX_SIGN_POS 15
`endif

//--- design/alu_exec.sv
// Top of the arithmetic, logic and branch execution datapath
`timescale 1ns/100ps
`include "alu_cfg.svh"
module alu_exec (
  input wire logic sys_clk, // 50 MHz clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic start, // Pulse: begin executing req
  input wire alu_pkg::request_s req, // Opcode, resolved operand, effective address
  output alu_pkg::result_s res, // Registers, memory write and branch
  output logic busy, // Instruction in progress
  output logic done // Pulse on the final cycle
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    alu_pkg::state_e st;
    logic [7:0] cnt;
    alu_pkg::request_s cur;
    alu_pkg::result_s r;
    logic busy;
    logic done;
  } state_s;
  state_s s_reg;
  state_s s_next;

  logic [23:0] add_a;
  logic [23:0] add_b;
  logic add_cin;
  logic [23:0] add_sum;
  logic add_cout;
  logic add_ovf;
  logic [23:0] mhi, mlo, q, rm;
  logic movf, dovf;

  alu_adder u_add (
    .a(add_a),
    .b(add_b),
    .cin(add_cin),
    .sum(add_sum),
    .cout(add_cout),
    .ovf(add_ovf)
  );
  alu_muldiv u_md (
    .acc(s_reg.r.acc),
    .ext(s_reg.r.ext),
    .opd(s_reg.cur.operand),
    .mul_hi(mhi),
    .mul_lo(mlo),
    .mul_ovf(movf),
    .quo(q),
    .rem(rm),
    .div_ovf(dovf)
  );

  function automatic logic [7:0] base_cycles(input logic [5:0] op);
    unique case (op)
      `OPC_AAM, `OPC_DEC, `OPC_INC: base_cycles = {3'h0, `CYC_MEM}; // RULE_03 RULE_10 RULE_11
      `OPC_MUL: base_cycles = {3'h0, `CYC_MUL}; // RULE_06
      `OPC_DIV: base_cycles = {3'h0, `CYC_DIV}; // RULE_08
      `OPC_JMP, `OPC_BIX: base_cycles = {3'h0, `CYC_BRANCH}; // RULE_15 RULE_16
      default: base_cycles = {3'h0, `CYC_LOGIC};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Adder operand selection
  // ----------------------------------------------------------------
  always_comb begin
    add_a = s_reg.r.acc;
    add_b = s_reg.cur.operand;
    add_cin = 1'b0;
    unique case (s_reg.cur.opcode)
      `OPC_ADC: add_cin = s_reg.r.spill; // RULE_02
      `OPC_SUB: begin
        add_b = ~s_reg.cur.operand; // RULE_04
        add_cin = 1'b1;
      end
      `OPC_SBC: begin
        add_b = ~s_reg.cur.operand; // RULE_05
        add_cin = s_reg.r.spill;
      end
      `OPC_DEC: begin
        add_a = s_reg.cur.operand;
        add_b = 24'hffffff; // RULE_10
      end
      `OPC_INC: begin
        add_a = s_reg.cur.operand;
        add_b = 24'h000000;
        add_cin = 1'b1; // RULE_11
      end
      default: ;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencing and commit
  // ----------------------------------------------------------------
  always_comb begin
    logic [23:0] nidx;
    nidx = s_reg.r.idx + 24'h000001;
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.r.mem_write = 1'b0;
    s_next.r.branch = 1'b0;
    unique case (s_reg.st)
      alu_pkg::ST_IDLE: begin
        if (start) begin
          s_next.cur = req;
          s_next.cnt = base_cycles(req.opcode) + {5'h00, req.indirect}; // RULE_17
          if (base_cycles(req.opcode) + {5'h00, req.indirect} == 8'h01) begin
            // One-cycle branches commit straight from idle; the run state would cost an extra edge
            s_next.done = 1'b1;
            s_next.r.target = req.ea; // RULE_15
            if (req.opcode == `OPC_BIX) begin
              s_next.r.idx = nidx;
              s_next.r.branch = nidx[`IDX_SIGN_POS]; // RULE_16
            end else begin
              s_next.r.branch = 1'b1; // RULE_15
            end
          end else begin
            s_next.st = alu_pkg::ST_RUN;
            s_next.busy = 1'b1;
          end
        end
      end
      alu_pkg::ST_RUN: begin
        s_next.cnt = s_reg.cnt - 8'h01;
        if (s_reg.cnt == 8'h02 || s_reg.cnt == 8'h01) begin
          s_next.cnt = 8'h00;
        end
        if (s_reg.cnt <= 8'h02) begin
          s_next.st = alu_pkg::ST_IDLE;
          s_next.busy = 1'b0;
          s_next.done = 1'b1;
          s_next.r.target = s_reg.cur.ea;
          unique case (s_reg.cur.opcode)
            `OPC_ADD, `OPC_ADC, `OPC_SUB, `OPC_SBC: begin
              s_next.r.acc = add_sum; // RULE_01 RULE_18
              s_next.r.spill = add_cout; // RULE_04
              s_next.r.ovf = s_reg.r.ovf | add_ovf; // RULE_01
            end
            `OPC_AAM, `OPC_DEC, `OPC_INC: begin
              s_next.r.mem_data = add_sum; // RULE_03
              s_next.r.mem_write = 1'b1;
              s_next.r.ovf = s_reg.r.ovf | add_ovf; // RULE_10
            end
            `OPC_MUL: begin
              s_next.r.acc = mhi; // RULE_06
              s_next.r.ext = mlo;
              s_next.r.ovf = s_reg.r.ovf | movf; // RULE_07
            end
            `OPC_DIV: begin
              s_next.r.acc = q; // RULE_08
              s_next.r.ext = rm;
              s_next.r.ovf = s_reg.r.ovf | dovf; // RULE_09
            end
            `OPC_AND: s_next.r.acc = s_reg.r.acc & s_reg.cur.operand; // RULE_12
            `OPC_OR: s_next.r.acc = s_reg.r.acc | s_reg.cur.operand; // RULE_13
            `OPC_XOR: s_next.r.acc = s_reg.r.acc ^ s_reg.cur.operand; // RULE_14
            `OPC_JMP: s_next.r.branch = 1'b1; // RULE_15
            `OPC_BIX: begin
              s_next.r.idx = nidx;
              s_next.r.branch = nidx[`IDX_SIGN_POS]; // RULE_16
            end
            default: ;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign res = s_reg.r;
  assign busy = s_reg.busy;
  assign done = s_reg.done;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_add_two_cycles: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_01
    start && !busy && req.opcode == `OPC_ADD && req.indirect == 3'h0 |=> ##1 done)
    else $error("add did not finish in two cycles");
  a_mem_three: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_03
    start && !busy && req.opcode == `OPC_AAM && req.indirect == 3'h0 |=> !done ##1 !done ##1 (done && res.mem_write))
    else $error("memory add timing wrong");
  a_mul_len: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_06
    start && !busy && req.opcode == `OPC_MUL && req.indirect == 3'h0 |=> ##13 done)
    else $error("multiply timing wrong");
  a_div_len: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_08
    start && !busy && req.opcode == `OPC_DIV && req.indirect == 3'h0 |=> ##27 done)
    else $error("divide timing wrong");
  a_jump_one: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_15
    start && !busy && req.opcode == `OPC_JMP && req.indirect == 3'h0 |=> done && res.branch)
    else $error("jump not taken in one cycle");
  a_indirect_extra: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_17
    start && !busy && req.opcode == `OPC_JMP && req.indirect == 3'h1 |=> !done ##1 done)
    else $error("indirect cycle not added");
  a_ovf_sticky: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_09
    res.ovf |=> res.ovf)
    else $error("overflow indicator dropped");
  a_mem_keeps_acc: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_10
    done && res.mem_write |-> res.acc == $past(res.acc))
    else $error("memory op changed main register");
  c_add: cover property (@(posedge sys_clk) done && s_reg.cur.opcode == `OPC_ADD);
  c_mul_ovf: cover property (@(posedge sys_clk) done && s_reg.cur.opcode == `OPC_MUL && res.ovf);
  c_bix_taken: cover property (@(posedge sys_clk) done && s_reg.cur.opcode == `OPC_BIX && res.branch);
endmodule // alu_exec

//--- design/alu_muldiv.sv
// Combinational signed multiply and divide kernel
`timescale 1ns/100ps
`include "alu_cfg.svh"
module alu_muldiv (
  input wire logic [23:0] acc, // Main register
  input wire logic [23:0] ext, // Extension register
  input wire logic [23:0] opd, // Memory operand
  output logic [23:0] mul_hi, // Product high word
  output logic [23:0] mul_lo, // Product low word
  output logic mul_ovf, // Both factors most negative
  output logic [23:0] quo, // Quotient
  output logic [23:0] rem, // Remainder, signed like dividend
  output logic div_ovf // Quotient out of range
);
  logic signed [47:0] prod;
  logic signed [47:0] dividend;
  logic signed [47:0] divisor;
  logic signed [47:0] q;
  logic signed [47:0] r;
  always_comb begin
    prod = $signed(acc) * $signed(opd);
    mul_ovf = (acc == `MOST_NEG) && (opd == `MOST_NEG); // RULE_07
    // Fractional scaling: drop the duplicate sign, extension lsb carries no weight
    mul_hi = mul_ovf ? 24'h000000 : prod[46:23]; // RULE_06
    mul_lo = mul_ovf ? 24'h000000 : {prod[22:0], 1'b0}; // RULE_06
    dividend = $signed({acc, ext[23:1]}) <<< 1;
    dividend = dividend >>> 1;
    divisor = {{24{opd[23]}}, opd};
    q = (opd == 24'h000000) ? 48'sh0 : dividend / divisor;
    r = (opd == 24'h000000) ? 48'sh0 : dividend % divisor; // RULE_08
    div_ovf = (opd == 24'h000000) || (q > 48'sh7fffff) || (q < -48'sh800000); // RULE_09
    quo = q[23:0];
    rem = r[23:0];
  end
endmodule // alu_muldiv

//--- design/alu_pkg.sv
// Types shared by the execution datapath and its testbench; the adder and multiply/divide kernels do not use them
package alu_pkg;
  typedef logic [23:0] word_t;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN} state_e;
  typedef struct packed {
    logic [5:0] opcode;
    logic [2:0] indirect;
    word_t operand;
    logic [14:0] ea;
  } request_s;
  typedef struct packed {
    word_t acc;
    word_t ext;
    word_t idx;
    word_t mem_data;
    logic mem_write;
    logic branch;
    logic [14:0] target;
    logic spill;
    logic ovf;
  } result_s;
endpackage

//--- testbench/alu_exec_test.sv
// Self-checking bench for the arithmetic, logic and branch execution datapath
`timescale 1ns/100ps
`include "alu_cfg.svh"
module alu_exec_test;
  `define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
  logic sys_clk = 1'h0;
  logic rstn = 1'h0;
  logic start = 1'h0;
  alu_pkg::request_s req = '0;
  alu_pkg::result_s res;
  logic busy;
  logic done;
  int bad_count = 0;
  int n_compared = 0;
  typedef struct {logic [5:0] op; logic [23:0] d; logic [2:0] ind; logic [3:0] ck; logic [2:0] f;
                  logic [23:0] a; logic [23:0] x;} row_s;
  // ----------------------------------------------------------------
  // Rows: ck = {acc, ext or mem, spill, ovf}; f = {reset first, spill, ovf}
  // ----------------------------------------------------------------
  row_s rows[29] = '{
    '{`OPC_OR, 24'h7ab9d4, 3'h0, 4'hb, 3'h4, 24'h7ab9d4, 24'h0},
    '{`OPC_ADD, 24'h6a6ee5, 3'h2, 4'hb, 3'h1, 24'he528b9, 24'h0},
    '{`OPC_OR, 24'h9d3d09, 3'h0, 4'h8, 3'h4, 24'h9d3d09, 24'h0},
    '{`OPC_ADD, 24'hdfa90d, 3'h1, 4'hb, 3'h3, 24'h7ce616, 24'h0},
    '{`OPC_AND, 24'h000000, 3'h0, 4'h8, 3'h0, 24'h000000, 24'h0},
    '{`OPC_OR, 24'h7ab9d4, 3'h0, 4'h8, 3'h0, 24'h7ab9d4, 24'h0},
    '{`OPC_ADC, 24'h6a6ee5, 3'h0, 4'hb, 3'h1, 24'he528ba, 24'h0},
    '{`OPC_OR, 24'h9d3d49, 3'h0, 4'h8, 3'h4, 24'h9d3d49, 24'h0},
    '{`OPC_SUB, 24'h205733, 3'h0, 4'hb, 3'h3, 24'h7ce616, 24'h0},
    '{`OPC_OR, 24'h9d3d49, 3'h0, 4'h8, 3'h4, 24'h9d3d49, 24'h0},
    '{`OPC_SBC, 24'h205733, 3'h3, 4'hb, 3'h3, 24'h7ce615, 24'h0},
    '{`OPC_OR, 24'h8fea91, 3'h0, 4'h8, 3'h4, 24'h8fea91, 24'h0},
    '{`OPC_AND, 24'h003fff, 3'h0, 4'h9, 3'h0, 24'h002a91, 24'h0},
    '{`OPC_OR, 24'hf9a06b, 3'h0, 4'h8, 3'h0, 24'hf9aafb, 24'h0},
    '{`OPC_XOR, 24'hffffff, 3'h0, 4'h8, 3'h0, 24'h065504, 24'h0},
    '{`OPC_XOR, 24'h065504, 3'h0, 4'h8, 3'h0, 24'h000000, 24'h0},
    '{`OPC_OR, 24'h000032, 3'h0, 4'h8, 3'h0, 24'h000032, 24'h0},
    '{`OPC_MUL, 24'h000007, 3'h1, 4'hd, 3'h0, 24'h000000, 24'h0002bc},
    '{`OPC_DIV, 24'h000007, 3'h0, 4'hd, 3'h0, 24'h000032, 24'h000000},
    '{`OPC_OR, 24'h800000, 3'h0, 4'h8, 3'h4, 24'h800000, 24'h0},
    '{`OPC_MUL, 24'h800000, 3'h0, 4'hd, 3'h1, 24'h000000, 24'h000000},
    '{`OPC_OR, 24'h000040, 3'h0, 4'h8, 3'h4, 24'h000040, 24'h0},
    '{`OPC_DIV, 24'h000007, 3'h0, 4'h1, 3'h1, 24'h0, 24'h0},
    '{`OPC_OR, 24'h000001, 3'h0, 4'h8, 3'h4, 24'h000001, 24'h0},
    '{`OPC_AAM, 24'hfffffe, 3'h0, 4'hf, 3'h0, 24'h000001, 24'hffffff},
    '{`OPC_AAM, 24'h7fffff, 3'h0, 4'hd, 3'h1, 24'h000001, 24'h800000},
    '{`OPC_INC, 24'h7fffff, 3'h0, 4'hd, 3'h5, 24'h000000, 24'h800000},
    '{`OPC_DEC, 24'h000000, 3'h0, 4'hd, 3'h4, 24'h000000, 24'hffffff},
    '{`OPC_DEC, 24'h800000, 3'h0, 4'hd, 3'h1, 24'h000000, 24'h7fffff}
  };

  alu_exec alu_exec_inst (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .start(start),
    .req(req),
    .res(res),
    .busy(busy),
    .done(done)
  );

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  function automatic logic mem_op(input logic [5:0] op);
    return op inside {`OPC_AAM, `OPC_INC, `OPC_DEC};
  endfunction

  function automatic logic [5:0] cyc(input logic [5:0] op);
    case (op)
      `OPC_MUL: return {1'h0, `CYC_MUL};
      `OPC_DIV: return {1'h0, `CYC_DIV};
      `OPC_JMP, `OPC_BIX: return {1'h0, `CYC_BRANCH};
      default: return mem_op(op) ? {1'h0, `CYC_MEM} : {1'h0, `CYC_LOGIC};
    endcase
  endfunction

  task automatic stop_test();
    if (bad_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic do_reset();
    start = 1'h0;
    rstn = 1'h0;
    repeat (5) @(posedge sys_clk);
    #1;
    rstn = 1'h1;
    @(posedge sys_clk);
    #1;
    `CHK({res, busy, done}, '0)
  endtask

  // Start stays high when done lands on the taking edge, so back-to-back
  // one-cycle operations never toggle it twice in one time step
  task automatic run(input logic [5:0] op, input logic [23:0] d, input logic [2:0] ind, input logic [14:0] ea,
                     input logic eb);
    logic [5:0] n;
    n = 6'h0;
    req = '{op, ind, d, ea};
    start = 1'h1;
    while (n < 6'h28) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (done) break;
      start = 1'h0;
    end
    if (!done) begin
      bad_count++;
      stop_test();
    end
    `CHK(n, cyc(op) + {3'h0, ind})
    `CHK(res.branch, eb)
    `CHK(res.mem_write, mem_op(op))
    if (eb) `CHK(res.target, ea)
  endtask

  initial begin
    do_reset();
    foreach (rows[i]) begin
      if (rows[i].f[2]) do_reset();
      run(rows[i].op, rows[i].d, rows[i].ind, 15'h0, 1'h0);
      if (rows[i].ck[3]) `CHK(res.acc, rows[i].a)
      if (rows[i].ck[2]) `CHK(mem_op(rows[i].op) ? res.mem_data : res.ext, rows[i].x)
      if (rows[i].ck[1]) `CHK(res.spill, rows[i].f[1])
      if (rows[i].ck[0]) `CHK(res.ovf, rows[i].f[0])
    end
    // ----------------------------------------------------------------
    // Branches, index wrap into the sign position, reset mid-divide
    // ----------------------------------------------------------------
    do_reset();
    run(`OPC_JMP, 24'h0, 3'h0, 15'h1234, 1'h1);
    run(`OPC_JMP, 24'h0, 3'h2, 15'h0abc, 1'h1);
    run(`OPC_BIX, 24'h0, 3'h1, 15'h0300, 1'h0);
    for (int k = 2; k <= 32768; k++) begin
      run(`OPC_BIX, 24'h0, 3'h0, 15'h0300, k[15]);
    end
    `CHK(res.idx, 24'h008000)
    req = '{`OPC_DIV, 3'h0, 24'h000003, 15'h0};
    @(posedge sys_clk);
    #1;
    start = 1'h0;
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK(busy, 1'h1)
    do_reset();
    stop_test();
  end
endmodule // alu_exec_test
